// ==== adc_start_pkg.sv ====
// ****************************************************************************
// Shared constants for the converter start and module standby block.
// ****************************************************************************
`default_nettype none

package adc_start_pkg;

	// ************************************************************************
	// Bus and register geometry.
	// ************************************************************************

	// Width of the Wishbone data bus.
	localparam int unsigned DATA_W = 32;
	// Width of the byte address; the word index is address bits 11 down to 2.
	localparam int unsigned ADDR_W = 12;
	// Width of a register word index.
	localparam int unsigned IDX_W = 10;
	// Width of each register.
	localparam int unsigned REG_W = 8;

	// ************************************************************************
	// Register indices; the byte address is four times the index.
	// ************************************************************************

	// Conversion start register.
	localparam logic [IDX_W-1:0] CONV_START_IDX = 10'h0C7;
	// Peripheral clock stop register.
	localparam logic [IDX_W-1:0] CLK_STOP_IDX = 10'h0D0;
	// Sticky event status register, write one to clear.
	localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 10'h0D1;
	// Interrupt mask register, same layout as the status register.
	localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 10'h0D2;

	// ************************************************************************
	// Field positions and reset values.
	// ************************************************************************

	// Conversion start flag position in the start register.
	localparam int unsigned START_FLAG_BIT = 7;
	// Reserved bits of the start register, always read as one.
	localparam logic [REG_W-1:0] START_RSVD_ONES = 8'h7F;
	// Converter clock stop bit in the clock stop register.
	localparam int unsigned CONV_CLK_STOP_BIT = 4;
	// Reset value of the clock stop register.
	localparam logic [REG_W-1:0] CLK_STOP_RESET = 8'hFF;

	// Event bits of the status and mask registers.
	localparam int unsigned EV_W = 3;
	localparam int unsigned EV_DONE_BIT = 0;
	localparam int unsigned EV_ABORT_BIT = 1;
	localparam int unsigned EV_REFUSED_BIT = 2;
	// Reset value of the status and mask registers.
	localparam logic [EV_W-1:0] EV_RESET = 3'h0;

	// Converter control states.
	typedef enum logic [0:0] {
		CONV_IDLE = 1'b0,
		CONV_RUN  = 1'b1
	} conv_state_t;

endpackage

`default_nettype wire

// ==== adc_start_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module adc_start_ctrl (
	// System clock and synchronous reset.
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst,
	// Classic Wishbone slave.
	input  wire logic                                  wb_cyc_i,
	input  wire logic                                  wb_stb_i,
	input  wire logic                                  wb_we_i,
	input  wire logic [adc_start_pkg::ADDR_W-1:0]      wb_adr_i,
	input  wire logic [adc_start_pkg::DATA_W/8-1:0]    wb_sel_i,
	input  wire logic [adc_start_pkg::DATA_W-1:0]      wb_dat_i,
	output logic                                       wb_ack_o,
	output logic      [adc_start_pkg::DATA_W-1:0]      wb_dat_o,
	// Converter datapath side.
	input  wire logic                                  conv_end_i,
	output logic                                       conv_run_o,
	output logic                                       conv_start_o,
	output logic                                       conv_abort_o,
	output logic                                       conv_clk_en_o,
	output logic                                       conv_standby_o,
	// All peripheral clock stop bits, the converter bit included.
	output logic      [adc_start_pkg::REG_W-1:0]       periph_clock_stop_o,
	// Interrupt request, level.
	output logic                                       irq_o
);

	// ************************************************************************
	// Helper functions.
	// ************************************************************************

	// Returns the word index held in a byte address.
	function automatic logic [adc_start_pkg::IDX_W-1:0] word_idx(
		input logic [adc_start_pkg::ADDR_W-1:0] adr
	);
		word_idx = adr[adc_start_pkg::ADDR_W-1:2];
	endfunction

	// Returns one when an accepted write targets the given register index.
	function automatic logic write_hit(
		input logic                              wr,
		input logic [adc_start_pkg::IDX_W-1:0]   idx,
		input logic [adc_start_pkg::IDX_W-1:0]   target
	);
		write_hit = wr && (idx == target);
	endfunction

	// ************************************************************************
	// Declarations.
	// ************************************************************************

	// Acknowledge register of the bus slave.
	logic                                  ack_q;
	// Registered read data.
	logic [adc_start_pkg::DATA_W-1:0]      rdata_q;
	// Word index of the current request.
	logic [adc_start_pkg::IDX_W-1:0]       idx;
	// Write commit strobe, high in the cycle that ack is given.
	logic                                  wr_commit;
	// Read data chosen by the address decoder.
	logic [adc_start_pkg::REG_W-1:0]       rd_mux;
	// Clock stop register.
	logic [adc_start_pkg::REG_W-1:0]       clk_stop_q;
	// Converter control state.
	adc_start_pkg::conv_state_t            state_q;
	adc_start_pkg::conv_state_t            state_d;
	// Start and abort pulses towards the datapath.
	logic                                  start_pulse_q;
	logic                                  abort_pulse_q;
	// Status and mask registers of the interrupt logic.
	logic [adc_start_pkg::EV_W-1:0]        stat_q;
	logic [adc_start_pkg::EV_W-1:0]        mask_q;
	// Per-register write strobes.
	logic                                  wr_start;
	logic                                  wr_clk_stop;
	logic                                  wr_stat;
	logic                                  wr_mask;
	// Decoded software requests on the start flag.
	logic                                  start_req;
	logic                                  stop_req;
	// Standby level derived from the clock stop bit.
	logic                                  standby;
	// One-cycle events feeding the status register.
	logic [adc_start_pkg::EV_W-1:0]        events;
	// Bits that software asks to clear in the status register.
	logic [adc_start_pkg::EV_W-1:0]        stat_clr;

	// ************************************************************************
	// Wishbone slave.
	// ************************************************************************

	// Every request is answered one cycle after it arrives, unmapped ones too.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	// Word index of the request.
	assign idx = word_idx(wb_adr_i);

	// A write takes effect on the edge at which the master samples ack, lane 0 only.
	assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

	// Per-register write strobes.
	assign wr_start    = write_hit(wr_commit, idx, adc_start_pkg::CONV_START_IDX);
	assign wr_clk_stop = write_hit(wr_commit, idx, adc_start_pkg::CLK_STOP_IDX);
	assign wr_stat     = write_hit(wr_commit, idx, adc_start_pkg::IRQ_STAT_IDX);
	assign wr_mask     = write_hit(wr_commit, idx, adc_start_pkg::IRQ_MASK_IDX);

	// Read decoder; unmapped addresses read as zero.
	always_comb begin
		rd_mux = '0;
		if (idx == adc_start_pkg::CONV_START_IDX) begin
			// Flag shows the live state, reserved bits always one.
			rd_mux = adc_start_pkg::START_RSVD_ONES;
			rd_mux[adc_start_pkg::START_FLAG_BIT] = (state_q == adc_start_pkg::CONV_RUN);
		end else if (idx == adc_start_pkg::CLK_STOP_IDX) begin
			rd_mux = clk_stop_q;
		end else if (idx == adc_start_pkg::IRQ_STAT_IDX) begin
			rd_mux[adc_start_pkg::EV_W-1:0] = stat_q;
		end else if (idx == adc_start_pkg::IRQ_MASK_IDX) begin
			rd_mux[adc_start_pkg::EV_W-1:0] = mask_q;
		end
	end

	// Read data is captured on the edge that raises ack, upper bits zero.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			rdata_q <= {{(adc_start_pkg::DATA_W-adc_start_pkg::REG_W){1'b0}}, rd_mux};
		end
	end

	// Bus outputs come straight from their flops.
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ************************************************************************
	// Clock stop register and module standby.
	// ************************************************************************

	// Fully writable byte, all ones after reset so every module runs.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_stop_q <= adc_start_pkg::CLK_STOP_RESET;
		end else if (wr_clk_stop) begin
			clk_stop_q <= wb_dat_i[adc_start_pkg::REG_W-1:0];
		end
	end

	// A zero in the converter bit holds the converter in standby.
	assign standby = !clk_stop_q[adc_start_pkg::CONV_CLK_STOP_BIT];

	// Standby outputs come straight from the register flop.
	assign conv_standby_o      = standby;
	assign conv_clk_en_o       = clk_stop_q[adc_start_pkg::CONV_CLK_STOP_BIT];
	assign periph_clock_stop_o = clk_stop_q;

	// ************************************************************************
	// Conversion control.
	// ************************************************************************

	// Software requests; the reserved bits of the write data are ignored.
	assign start_req = wr_start && wb_dat_i[adc_start_pkg::START_FLAG_BIT];
	assign stop_req  = wr_start && !wb_dat_i[adc_start_pkg::START_FLAG_BIT];

	// Next state and the events that the transitions raise.
	always_comb begin
		state_d = state_q;
		events  = '0;
		case (state_q)
			adc_start_pkg::CONV_IDLE: begin
				if (start_req && standby) begin
					// A start in standby is refused and reported.
					events[adc_start_pkg::EV_REFUSED_BIT] = 1'b1;
				end else if (start_req) begin
					state_d = adc_start_pkg::CONV_RUN;
				end
			end
			adc_start_pkg::CONV_RUN: begin
				if (stop_req || standby) begin
					// Stop by software, or converter clock removed mid-way.
					state_d = adc_start_pkg::CONV_IDLE;
					events[adc_start_pkg::EV_ABORT_BIT] = 1'b1;
				end else if (conv_end_i) begin
					// Datapath finished; the flag falls back to zero.
					state_d = adc_start_pkg::CONV_IDLE;
					events[adc_start_pkg::EV_DONE_BIT] = 1'b1;
				end
			end
			default: begin
				state_d = adc_start_pkg::CONV_IDLE;
			end
		endcase
	end

	// State register; idle after reset, so the flag reads zero.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= adc_start_pkg::CONV_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// One-cycle start and abort pulses towards the datapath.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_pulse_q <= 1'b0;
			abort_pulse_q <= 1'b0;
		end else begin
			start_pulse_q <= (state_q == adc_start_pkg::CONV_IDLE) && (state_d == adc_start_pkg::CONV_RUN);
			abort_pulse_q <= events[adc_start_pkg::EV_ABORT_BIT];
		end
	end

	// Run level follows the state flop; both pulses come from flops.
	assign conv_run_o   = (state_q == adc_start_pkg::CONV_RUN);
	assign conv_start_o = start_pulse_q;
	assign conv_abort_o = abort_pulse_q;

	// ************************************************************************
	// Interrupt status and mask.
	// ************************************************************************

	// Bits that software writes as one are cleared.
	assign stat_clr = wr_stat ? wb_dat_i[adc_start_pkg::EV_W-1:0] : '0;

	// Sticky status; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_q <= adc_start_pkg::EV_RESET;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | events;
		end
	end

	// Mask register, plain read/write.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_q <= adc_start_pkg::EV_RESET;
		end else if (wr_mask) begin
			mask_q <= wb_dat_i[adc_start_pkg::EV_W-1:0];
		end
	end

	// Level interrupt while any unmasked status bit is set.
	assign irq_o = |(stat_q & mask_q);

	// ************************************************************************
	// Assertions.
	// ************************************************************************

	// All checks run on the system clock and rest while reset is applied.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Read of the start register answered in the acknowledge cycle.
	sequence start_read_s;
		wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q && (idx == adc_start_pkg::CONV_START_IDX);
	endsequence

	// Start accepted while the converter is idle and clocked.
	sequence start_ok_s;
		start_req && !standby && !conv_run_o;
	endsequence

	// An accepted start raises the run level and a single start pulse.
	start_begins_a: assert property (start_ok_s |=> conv_run_o ##0 conv_start_o ##1 !conv_start_o)
		else $error("accepted start did not begin a conversion");

	// A stop write ends a running conversion and reports the abort.
	stop_halts_a: assert property (stop_req && conv_run_o |=> !conv_run_o && conv_abort_o && stat_q[adc_start_pkg::EV_ABORT_BIT])
		else $error("stop write did not end the running conversion");

	// The flag read back shows the state at the edge that captured it.
	flag_reads_a: assert property (start_read_s |=> wb_ack_o && (wb_dat_o[adc_start_pkg::START_FLAG_BIT] == $past(conv_run_o)))
		else $error("start flag read does not match conversion state");

	// Completion by the datapath drops the flag and reports it.
	done_clears_a: assert property (conv_run_o && conv_end_i && !wr_start && !standby |=> !conv_run_o && stat_q[adc_start_pkg::EV_DONE_BIT])
		else $error("completed conversion left the flag set");

	// The reserved bits of the start register always read as one.
	reserved_ones_a: assert property (start_read_s |=> (wb_dat_o[adc_start_pkg::REG_W-2:0] == adc_start_pkg::START_RSVD_ONES[adc_start_pkg::REG_W-2:0]))
		else $error("reserved start bits did not read as one");

	// Clearing the converter bit enters standby and ends any conversion.
	standby_enter_a: assert property (wr_clk_stop && !wb_dat_i[adc_start_pkg::CONV_CLK_STOP_BIT] |=> conv_standby_o && !conv_clk_en_o ##1 !conv_run_o)
		else $error("clearing the clock stop bit did not enter standby");

	// Setting the converter bit leaves standby at once.
	standby_leave_a: assert property (wr_clk_stop && wb_dat_i[adc_start_pkg::CONV_CLK_STOP_BIT] |=> !conv_standby_o && conv_clk_en_o)
		else $error("setting the clock stop bit did not leave standby");

	// The clock stop register takes the whole written byte.
	clk_stop_rw_a: assert property (wr_clk_stop |=> (periph_clock_stop_o == $past(wb_dat_i[adc_start_pkg::REG_W-1:0])))
		else $error("clock stop register did not take the written byte");

	// A start in standby leaves the converter idle and is reported.
	no_start_standby_a: assert property (start_req && standby && !conv_run_o |=> (!conv_run_o)[*2] ##0 stat_q[adc_start_pkg::EV_REFUSED_BIT])
		else $error("conversion started while in module standby");

	// A refused start raises no start pulse towards the datapath.
	refused_quiet_a: assert property (start_req && standby |=> !conv_start_o)
		else $error("start pulse issued while in standby");

	// The abort pulse lasts one cycle and follows a running conversion.
	abort_pulse_a: assert property (conv_abort_o |-> $past(conv_run_o) && !conv_run_o ##1 !conv_abort_o)
		else $error("abort pulse without a running conversion");

	// Every accepted request is answered in the next cycle, for one cycle only.
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !ack_q |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus request not answered by a single acknowledge");

	// A new event survives a clear of the same bit in the same cycle.
	event_sticky_a: assert property ((events != '0) |=> ((stat_q & $past(events)) == $past(events)))
		else $error("status bit lost its event");

	// An unmasked event raises the interrupt in the cycle after the event, as soon as it is latched.
	irq_level_a: assert property (((events & mask_q) != '0) && !wr_mask |=> irq_o)
		else $error("unmasked event did not raise the interrupt");

endmodule

`default_nettype wire

// ==== adc_start_and_module_standby_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module adc_start_and_module_standby_tb;

	// ************************************************************************
	// Stimulus and observation signals.
	// ************************************************************************

	logic        clk_sys;       // System clock, 100 MHz.
	logic        rst;           // Synchronous reset, active high.
	logic        wb_cyc, wb_stb, wb_we;
	logic [11:0] wb_adr;        // Byte address, word index in bits 11:2.
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat;
	logic        wb_ack_o;
	logic [31:0] wb_dat_o;
	logic        conv_end;      // Completion pulse from the datapath.
	logic        conv_run_o, conv_start_o, conv_abort_o;
	logic        conv_clk_en_o, conv_standby_o, irq_o;
	logic [7:0]  periph_clock_stop_o;
	int          error_cnt = 0; // Mismatches seen.
	int          checks = 0;    // Comparisons made.
	int          n_start = 0;   // Cycles with the start pulse high.
	int          n_abort = 0;   // Cycles with the abort pulse high.
	logic [7:0]  rd;

	adc_start_ctrl uut (
		.clk_sys(clk_sys), .rst(rst),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.conv_end_i(conv_end), .conv_run_o(conv_run_o), .conv_start_o(conv_start_o),
		.conv_abort_o(conv_abort_o), .conv_clk_en_o(conv_clk_en_o),
		.conv_standby_o(conv_standby_o), .periph_clock_stop_o(periph_clock_stop_o),
		.irq_o(irq_o)
	);

	// ************************************************************************
	// Clock, pulse counters and common tasks.
	// ************************************************************************

	// The clock toggles every half period of 5 ns.
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Pulse counters show both that a pulse came and that it lasted one cycle.
	always @(posedge clk_sys) begin
		if (conv_start_o === 1'b1) n_start++;
		if (conv_abort_o === 1'b1) n_abort++;
	end

	// Compares a seen value with the expected one and reports a difference.
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; the request holds until ack is sampled high.
	task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] d,
		input logic [3:0] sel, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= sel;
		wb_dat <= {24'h000000, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) check(32'h00000001, 32'h00000000);
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// Register write through lane 0.
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, 4'h1, q);
	endtask

	// Register read.
	task automatic rd_reg(input logic [9:0] idx, output logic [7:0] q);
		bus(1'b0, idx, 8'h00, 4'hF, q);
	endtask

	// Lets a few edges pass so that registered outputs settle.
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// ************************************************************************
	// Scenarios.
	// ************************************************************************

	// Reset values, reserved bits and an unmapped address.
	task automatic t_reset();
		rd_reg(adc_start_pkg::CONV_START_IDX, rd); check(rd, 8'h7F);
		rd_reg(adc_start_pkg::CLK_STOP_IDX, rd); check(rd, 8'hFF);
		check(wb_dat_o, 32'h000000FF);
		check(conv_clk_en_o, 1'b1);
		check(conv_standby_o, 1'b0);
		rd_reg(10'h001, rd); check(rd, 8'h00);
		wr(adc_start_pkg::CONV_START_IDX, 8'h00);
		rd_reg(adc_start_pkg::CONV_START_IDX, rd); check(rd, 8'h7F);
	endtask

	// Start, run, completion, done event and its interrupt.
	task automatic t_complete();
		int s;
		s = n_start;
		wr(adc_start_pkg::CONV_START_IDX, 8'h80);
		settle();
		check(conv_run_o, 1'b1);
		check(n_start - s, 1);
		rd_reg(adc_start_pkg::CONV_START_IDX, rd); check(rd, 8'hFF);
		@(posedge clk_sys) conv_end <= 1'b1;
		@(posedge clk_sys) conv_end <= 1'b0;
		settle();
		check(conv_run_o, 1'b0);
		rd_reg(adc_start_pkg::CONV_START_IDX, rd); check(rd, 8'h7F);
		rd_reg(adc_start_pkg::IRQ_STAT_IDX, rd); check(rd[2:0], 3'h1);
		check(irq_o, 1'b0);
		wr(adc_start_pkg::IRQ_MASK_IDX, 8'h01);
		rd_reg(adc_start_pkg::IRQ_MASK_IDX, rd); check(rd, 8'h01);
		settle();
		check(irq_o, 1'b1);
		wr(adc_start_pkg::IRQ_STAT_IDX, 8'h01);
		settle();
		check(irq_o, 1'b0);
	endtask

	// A zero written while converting stops the conversion.
	task automatic t_stop();
		int a;
		wr(adc_start_pkg::CONV_START_IDX, 8'h80);
		a = n_abort;
		wr(adc_start_pkg::CONV_START_IDX, 8'h00);
		settle();
		check(conv_run_o, 1'b0);
		check(n_abort - a, 1);
		rd_reg(adc_start_pkg::IRQ_STAT_IDX, rd); check(rd[2:0], 3'h2);
		wr(adc_start_pkg::IRQ_STAT_IDX, 8'h07);
	endtask

	// Standby entry aborts a running conversion and refuses a start; leaving it works again.
	task automatic t_standby();
		int s;
		int a;
		wr(adc_start_pkg::CONV_START_IDX, 8'h80);
		a = n_abort;
		wr(adc_start_pkg::CLK_STOP_IDX, 8'hEF);
		settle();
		check(conv_run_o, 1'b0);
		check(n_abort - a, 1);
		check(conv_standby_o, 1'b1);
		check(conv_clk_en_o, 1'b0);
		check(periph_clock_stop_o, 8'hEF);
		rd_reg(adc_start_pkg::CLK_STOP_IDX, rd); check(rd, 8'hEF);
		s = n_start;
		wr(adc_start_pkg::CONV_START_IDX, 8'h80);
		settle();
		check(conv_run_o, 1'b0);
		check(n_start - s, 0);
		rd_reg(adc_start_pkg::IRQ_STAT_IDX, rd); check(rd[2:0], 3'h6);
		wr(adc_start_pkg::IRQ_STAT_IDX, 8'h07);
		wr(adc_start_pkg::CLK_STOP_IDX, 8'hFF);
		settle();
		check(conv_standby_o, 1'b0);
		check(conv_clk_en_o, 1'b1);
		wr(adc_start_pkg::CONV_START_IDX, 8'h80);
		settle();
		check(conv_run_o, 1'b1);
		wr(adc_start_pkg::CONV_START_IDX, 8'h00);
		wr(adc_start_pkg::IRQ_STAT_IDX, 8'h07);
	endtask

	// A write with lane 0 disabled leaves the register alone.
	task automatic t_sel();
		logic [7:0] q;
		bus(1'b1, adc_start_pkg::CLK_STOP_IDX, 8'h00, 4'hE, q);
		rd_reg(adc_start_pkg::CLK_STOP_IDX, rd); check(rd, 8'hFF);
	endtask

	// ************************************************************************
	// Verdict, watchdog and main sequence.
	// ************************************************************************

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk_sys);
		error_cnt++;
		report_and_stop();
	end

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_dat = 32'h00000000;
		conv_end = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_complete();
		t_stop();
		t_standby();
		t_sel();
		report_and_stop();
	end

endmodule

`default_nettype wire
